// ### dv/fbir_regs_properties.sv
// checker for bus timing and word contents of the build info bank
`timescale 1ns/1ps
module fbir_regs_chk (
  input logic        sys_clk_in,
  input logic        rst_in,
  input logic [7:0]  s_axi_araddr_in,
  input logic        s_axi_arvalid_in,
  input logic        s_axi_arready_out,
  input logic [31:0] s_axi_rdata_out,
  input logic [1:0]  s_axi_rresp_out,
  input logic        s_axi_rvalid_out,
  input logic        s_axi_rready_in,
  input logic        s_axi_awvalid_in,
  input logic        s_axi_awready_out,
  input logic [1:0]  s_axi_bresp_out,
  input logic        s_axi_bvalid_out,
  input logic        s_axi_bready_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // a read is taken at one edge and answered at the next
  sequence ar_take; s_axi_arvalid_in && s_axi_arready_out; endsequence
  sequence r_ok; s_axi_rvalid_out && s_axi_rresp_out == 2'h0; endsequence
  AST_DATE_WORD: assert property (ar_take ##0 s_axi_araddr_in == 8'h00
    |=> r_ok ##0 s_axi_rdata_out == 32'h12182012) else $error("bad date");
  AST_TIME_WORD: assert property (ar_take ##0 s_axi_araddr_in == 8'h04
    |=> r_ok ##0 s_axi_rdata_out == 32'h015A2335) else $error("bad time");
  AST_AR_ANSWER: assert property ($rose(s_axi_arvalid_in)
    && !s_axi_rvalid_out |=> s_axi_arready_out ##1 s_axi_rvalid_out)
    else $error("slow read");
  AST_AR_PULSE: assert property (s_axi_arready_out |=> !s_axi_arready_out)
    else $error("arready stuck");
  AST_AW_PULSE: assert property (s_axi_awready_out |=> !s_axi_awready_out)
    else $error("awready stuck");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("r lost");
  AST_B_ANSWER: assert property (s_axi_awvalid_in && s_axi_awready_out
    |-> ##[1:4] s_axi_bvalid_out) else $error("no write answer");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("b lost");
endmodule // fbir_regs_chk
bind fbir_regs fbir_regs_chk i_chk (.*);

// ### dv/fbir_regs_test.sv
// self-checking bench for the build info bank
`timescale 1ns/1ps
module fbir_regs_test;
  logic        sys_clk_in = 0;
  logic        rst_in = 1;
  logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h00000000, s_axi_rdata_out, d;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
  logic        s_axi_bready_in = 0, s_axi_arvalid_in = 0;
  logic        s_axi_rready_in = 0, s_axi_awready_out, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  int          n_errors = 0, samples_checked = 0;
  fbir_regs i_dut (.*);
  initial forever #2 sys_clk_in = ~sys_clk_in;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // late holds ready off for a while so the slave must keep its answer
  task rd(input logic [7:0] a, input bit late);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    s_axi_rready_in <= !late;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out === 1) s_axi_arvalid_in <= 0;
    end while (s_axi_rvalid_out !== 1);
    if (late) begin
      repeat (2) @(posedge sys_clk_in);
      s_axi_rready_in <= 1;
      @(posedge sys_clk_in);
    end
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 0;
  endtask
  task wr(input logic [7:0] a, input bit late);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= 32'hFFFFFFFF;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    s_axi_bready_in <= !late;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out === 1) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out === 1) s_axi_wvalid_in <= 0;
    end while (s_axi_bvalid_out !== 1);
    if (late) begin
      repeat (2) @(posedge sys_clk_in);
      s_axi_bready_in <= 1;
      @(posedge sys_clk_in);
    end
    r = s_axi_bresp_out;
    s_axi_bready_in <= 0;
  endtask
  task t_date;
    rd(8'h00, 1);
    chk(d, 32'h12182012);
  endtask
  task t_time;
    rd(8'h04, 0);
    chk(d, 32'h015A2335);
    chk({30'h0, r}, 32'h00000000);
  endtask
  task t_write;
    wr(8'h00, 0);
    chk({30'h0, r}, 32'h00000000);
    wr(8'h04, 1);
    chk({30'h0, r}, 32'h00000000);
    t_date();
    t_time();
  endtask
  task t_bad;
    rd(8'h08, 0);
    chk({d[31:2], r}, 32'h00000002);
    wr(8'h0C, 0);
    chk({30'h0, r}, 32'h00000002);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 0;
    t_date();
    t_time();
    t_write();
    t_bad();
    end_sim();
  end
  // about fifty cycles are needed; twenty times that means a hang
  initial begin
    #4000;
    n_errors++;
    end_sim();
  end
endmodule // fbir_regs_test

// ### rtl/fbir_const_words.v
// assembles the two constant build words from their fields
`timescale 1ns/1ps
module fbir_const_words #(
  parameter [15:0] YEAR_BCD   = 16'h2012,
  parameter [7:0]  MONTH_BCD  = 8'h12,
  parameter [7:0]  DAY_BCD    = 8'h18,
  parameter [7:0]  HOUR_BCD   = 8'h23,
  parameter [7:0]  MINUTE_BCD = 8'h35,
  parameter [7:0]  PART_ID    = 8'h5A,
  parameter [7:0]  COMPAT_VER = 8'h01
) (
  output wire [31:0] date_word_out,
  output wire [31:0] time_word_out
);
`include "fbir_map.vh"
  // fields are elaboration constants, so no write can reach them
  assign date_word_out[`FBIR_YEAR_MSB:`FBIR_YEAR_LSB]   = YEAR_BCD;
  assign date_word_out[`FBIR_DAY_MSB:`FBIR_DAY_LSB]     = DAY_BCD;
  assign date_word_out[`FBIR_MONTH_MSB:`FBIR_MONTH_LSB] = MONTH_BCD;
  assign time_word_out[`FBIR_MIN_MSB:`FBIR_MIN_LSB]     = MINUTE_BCD;
  assign time_word_out[`FBIR_HOUR_MSB:`FBIR_HOUR_LSB]   = HOUR_BCD;
  assign time_word_out[`FBIR_PART_MSB:`FBIR_PART_LSB]   = PART_ID;
  assign time_word_out[`FBIR_COMPAT_MSB:`FBIR_COMPAT_LSB] = COMPAT_VER;
endmodule // fbir_const_words

// ### rtl/fbir_map.vh
// register offsets, field positions and defaults for the build info bank
`ifndef FBIR_MAP_VH
`define FBIR_MAP_VH
// word indices of the two build words (byte address is index times four)
`define FBIR_IDX_DATE          6'h00
`define FBIR_IDX_TIME          6'h01
`define FBIR_ADDR_W            8
`define FBIR_IDX_LSB           2
// first build word fields
`define FBIR_YEAR_LSB          0
`define FBIR_YEAR_MSB          15
`define FBIR_DAY_LSB           16
`define FBIR_DAY_MSB           23
`define FBIR_MONTH_LSB         24
`define FBIR_MONTH_MSB         31
// second build word fields
`define FBIR_MIN_LSB           0
`define FBIR_MIN_MSB           7
`define FBIR_HOUR_LSB          8
`define FBIR_HOUR_MSB          15
`define FBIR_PART_LSB          16
`define FBIR_PART_MSB          23
`define FBIR_COMPAT_LSB        24
`define FBIR_COMPAT_MSB        31
// axi responses
`define FBIR_RESP_OKAY         2'h0
`define FBIR_RESP_SLVERR       2'h2
`define FBIR_ZERO32            32'h00000000
`endif

// ### rtl/fbir_read_mux.v
// selects the read word for a register index
`timescale 1ns/1ps
module fbir_read_mux (
  input  wire [5:0]  index_in,
  input  wire [31:0] date_word_in,
  input  wire [31:0] time_word_in,
  output reg  [31:0] data_out,
  output reg         hit_out
);
`include "fbir_map.vh"
  // unmapped indices read zero and flag a miss
  always @* begin
    data_out = `FBIR_ZERO32;
    hit_out  = 1'b1;
    case (index_in)
      `FBIR_IDX_DATE: data_out = date_word_in;
      `FBIR_IDX_TIME: data_out = time_word_in;
      default:        hit_out  = 1'b0;
    endcase
  end
endmodule // fbir_read_mux

// ### rtl/fbir_regs.v
// axi4-lite slave exposing the read-only image build information
// Summary of operation
// - The build year is shown as four bcd digits in bits 15..0 of word 0.
// - The build day is shown as two bcd digits in bits 23..16 of word 0.
// - The build month is shown as two bcd digits in bits 31..24 of word 0.
// - The build minute is shown as two bcd digits in bits 7..0 of word 1.
// - The build hour (0-23) is shown as bcd digits in bits 15..8 of word 1.
// - An eight-bit logic part identifier is shown in bits 23..16 of word 1.
// - A compatibility version in bits 31..24 of word 1 is checked by drivers.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fbir_regs #(
  parameter [15:0] YEAR_BCD   = 16'h2012,
  parameter [7:0]  MONTH_BCD  = 8'h12,
  parameter [7:0]  DAY_BCD    = 8'h18,
  parameter [7:0]  HOUR_BCD   = 8'h23,
  parameter [7:0]  MINUTE_BCD = 8'h35,
  parameter [7:0]  PART_ID    = 8'h5A,  // arbitrary value
  parameter [7:0]  COMPAT_VER = 8'h01
) (
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in
);
`include "fbir_map.vh"

  wire [31:0] date_word;
  wire [31:0] time_word;
  wire [31:0] rd_word;
  wire        rd_hit;
  wire        wr_hit;
  reg         aw_got;
  reg         w_got;
  reg  [5:0]  aw_index;

  fbir_const_words #(
    .YEAR_BCD   (YEAR_BCD),
    .MONTH_BCD  (MONTH_BCD),
    .DAY_BCD    (DAY_BCD),
    .HOUR_BCD   (HOUR_BCD),
    .MINUTE_BCD (MINUTE_BCD),
    .PART_ID    (PART_ID),
    .COMPAT_VER (COMPAT_VER)
  ) u_words (
    .date_word_out (date_word),
    .time_word_out (time_word)
  );

  // read decode on the request address
  fbir_read_mux u_rmux (
    .index_in     (s_axi_araddr_in[`FBIR_ADDR_W-1:`FBIR_IDX_LSB]),
    .date_word_in (date_word),
    .time_word_in (time_word),
    .data_out     (rd_word),
    .hit_out      (rd_hit)
  );

  // write decode only decides okay against slverr
  fbir_read_mux u_wmux (
    .index_in     (aw_index),
    .date_word_in (date_word),
    .time_word_in (time_word),
    .data_out     (),
    .hit_out      (wr_hit)
  );

  // write channel: address and data taken in either order, then response
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `FBIR_RESP_OKAY;
      aw_got            <= 1'b0;
      w_got             <= 1'b0;
      aw_index          <= 6'h00;
    end else begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      if (s_axi_awvalid_in && !aw_got && !s_axi_awready_out &&
          !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && !w_got && !s_axi_wready_out &&
          !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
      if (s_axi_awready_out && s_axi_awvalid_in) begin
        aw_got   <= 1'b1;
        aw_index <= s_axi_awaddr_in[`FBIR_ADDR_W-1:`FBIR_IDX_LSB];
      end
      if (s_axi_wready_out && s_axi_wvalid_in) begin
        w_got <= 1'b1;
      end
      // data is dropped: the words are constants
      if (aw_got && w_got && !s_axi_bvalid_out) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `FBIR_RESP_OKAY : `FBIR_RESP_SLVERR;
        aw_got           <= 1'b0;
        w_got            <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // read channel: one-cycle ready pulse, data registered with the take
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= `FBIR_ZERO32;
      s_axi_rresp_out   <= `FBIR_RESP_OKAY;
    end else begin
      s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out &&
                           !s_axi_rvalid_out;
      if (s_axi_arready_out && s_axi_arvalid_in) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_word;
        s_axi_rresp_out  <= rd_hit ? `FBIR_RESP_OKAY : `FBIR_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule // fbir_regs
